// [cswd_pkg.sv]
// cswd_pkg: constants and carriers for the bus sleep, wake-up and
// diagnostic controller. assumes a 200 MHz system clock.
package cswd_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // wake pattern timing, in their own units
  localparam int unsigned WAKE_MIN_PULSE_NS = 500;
  localparam int unsigned WAKE_MAX_PULSE_US = 500;
  localparam int unsigned WAKE_MAX_GAP_US   = 500;
  localparam int unsigned WAKE_WINDOW_US    = 1000;
  localparam int unsigned WAKE_PULSES       = 3;

  // derived cycle counts: least times round up, longest round down
  localparam int unsigned WAKE_MIN_CYC =
    (WAKE_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_MAX_CYC =
    (WAKE_MAX_PULSE_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_GAP_CYC =
    (WAKE_MAX_GAP_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_WIN_CYC =
    (WAKE_WINDOW_US * 1000000) / CLK_PERIOD_PS;

  // diagnostics
  localparam int unsigned DIAG_CONFIRM_CYCLES = 5;

  // register map (word offsets of the plain register port)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_DIAG   = 4'h2;

  // control register fields
  localparam int unsigned CTRL_SLEEP_BIT = 0;
  localparam int unsigned CTRL_WAKE_BIT  = 1;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // status register fields
  localparam int unsigned ST_WAKE_BIT  = 0;
  localparam int unsigned ST_FAIL_BIT  = 1;
  localparam int unsigned ST_UNID_BIT  = 2;
  localparam int unsigned ST_SLEEP_BIT = 3;

  // chip power states
  typedef enum logic [3:0] {
    CSWD_PWR_NORMAL  = 4'h1,
    CSWD_PWR_STANDBY = 4'h2,
    CSWD_PWR_STOP    = 4'h4,
    CSWD_PWR_SLEEP   = 4'h8
  } cswd_pwr_e;

  // bus failure codes
  typedef enum logic [2:0] {
    CSWD_FAIL_NONE     = 3'h0,
    CSWD_FAIL_LO_GND   = 3'h1,
    CSWD_FAIL_HI_GND   = 3'h2,
    CSWD_FAIL_LO_BATT  = 3'h3,
    CSWD_FAIL_HI_BATT  = 3'h4,
    CSWD_FAIL_LO_SUPP  = 3'h5,
    CSWD_FAIL_HI_SUPP  = 3'h6,
    CSWD_FAIL_UNKNOWN  = 3'h7
  } cswd_fail_e;

  // single-ended comparator outputs
  typedef struct packed {
    logic low_line_gnd_comparator;
    logic high_line_gnd_comparator;
    logic low_line_batt_comparator;
    logic high_line_batt_comparator;
    logic low_line_supply_comparator;
    logic high_line_supply_comparator;
  } cswd_cmp_s;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cswd_req_s;

endpackage : cswd_pkg

// [cswd_ctrl.sv]
// cswd_ctrl: sleep/active mode control, pattern wake-up detection,
// wake reporting and bus short classification of a bus transceiver.
// assumes all inputs synchronous to clk_i and a single-cycle register
// port with read data one cycle after the read strobe.
`timescale 1ns/1ps

// integration notes
// - the register port never stalls: a write lands on the strobe edge,
//   a read answer stands in the one cycle after the read strobe and the
//   read data port is zero in every other cycle
// - control bit 0 selects bus sleep, bit 1 arms the pattern wake-up;
//   bit 1 alone has no effect while the interface is active
// - the transceiver supply state is deliberately not an input: sleep
//   entry is accepted whether that supply is up or down
// - in bus sleep the drivers, the recessive bias and the normal
//   receiver are all off, so the lines float toward ground; leaving
//   sleep brings the bias, receiver and driver back on the same edge
// - wake timing is counted on clk_i; the defaults assume 5 ns, so a
//   slower clock needs the cycle parameters scaled by the integrator
// - pulse widths exactly on a bound are rejected; the counters saturate
//   so a stuck dominant wake line cannot wrap round into a false pulse
// - one wake event is reported once per sleep period; further patterns
//   are ignored until software returns the interface to active mode
// - the wake flag is sticky: it needs active mode and a status read
//   to clear, and a new wake in the same cycle wins over that read
// - regulator enable and reset release are levels; they drop when the
//   chip power state leaves its deepest sleep
// - the failure flag has no software clear; only reset removes it,
//   which keeps a transient short visible to slow polling software
//
module cswd_ctrl
  import cswd_pkg::*;
#(
  parameter int unsigned MIN_CYC = WAKE_MIN_CYC,
  parameter int unsigned MAX_CYC = WAKE_MAX_CYC,
  parameter int unsigned GAP_CYC = WAKE_GAP_CYC,
  parameter int unsigned WIN_CYC = WAKE_WIN_CYC,
  parameter int unsigned TW      = 18
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       clk_en_i,
  // register port
  input  wire cswd_req_s  req_i,
  output logic [7:0]      rdata_o,
  // chip power state
  input  wire cswd_pwr_e  pwr_state_i,
  // host transmit/receive
  input  wire logic       txd_i,
  output logic            rxd_o,
  // bus line front end
  input  wire logic       bus_diff_dominant_i,
  input  wire logic       wake_rx_dominant_i,
  input  wire cswd_cmp_s  cmp_i,
  output logic            drive_dominant_o,
  output logic            bias_recessive_o,
  output logic            rx_enable_o,
  // wake reporting
  output logic            regulator_on_o,
  output logic            mcu_reset_release_o,
  output logic            int_pulse_o
);

  ////////////////////////////////////////////////////////////////////
  // register port decode
  logic [7:0] ctrl;
  logic       sleep_mode;
  logic       wake_en;
  logic       bus_wake_flag;
  logic       fail_flag;
  logic       failure_unidentified_flag;
  cswd_fail_e fail_code;

  wire wr_ctrl = req_i.wr && (req_i.addr == REG_CTRL);
  wire rd_stat = req_i.rd && (req_i.addr == REG_STATUS);
  wire go_active = wr_ctrl && !req_i.wdata[CTRL_SLEEP_BIT];
  wire go_sleep  = wr_ctrl && req_i.wdata[CTRL_SLEEP_BIT];
  wire go_wake_sleep = go_sleep && req_i.wdata[CTRL_WAKE_BIT];

  wire [7:0] status_word = {4'h0, sleep_mode, failure_unidentified_flag,
                            fail_flag, bus_wake_flag};
  wire [7:0] diag_word   = {5'h00, fail_code};
  wire [7:0] next_rdata  =
    !req_i.rd                    ? 8'h00 :
    (req_i.addr == REG_CTRL)     ? ctrl :
    (req_i.addr == REG_STATUS)   ? status_word :
    (req_i.addr == REG_DIAG)     ? diag_word : 8'h00;

  // supply state is not an input: sleep entry never depends on it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl    <= CTRL_RESET;
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      rdata_o <= next_rdata;
      if (wr_ctrl) begin
        ctrl <= req_i.wdata;
      end
    end
  end

  assign sleep_mode = ctrl[CTRL_SLEEP_BIT];
  assign wake_en    = ctrl[CTRL_WAKE_BIT];

  ////////////////////////////////////////////////////////////////////
  // transmit/receive path
  wire next_drive = !sleep_mode && !txd_i;
  wire next_rxd   = sleep_mode ? 1'b1 : !bus_diff_dominant_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drive_dominant_o <= 1'b0;
      bias_recessive_o <= 1'b0;
      rx_enable_o      <= 1'b0;
      rxd_o            <= 1'b1;
    end else if (clk_en_i) begin
      drive_dominant_o <= next_drive;
      bias_recessive_o <= !sleep_mode;
      rx_enable_o      <= !sleep_mode;
      rxd_o            <= next_rxd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pattern wake-up: width filter, pulse counter, gap and window timers
  //
  // the wake receiver input is sampled once per clock; a dominant run
  // is measured by width_cnt and judged on its falling edge, or earlier
  // once it has grown too long to ever qualify
  // gap_cnt measures recessive time since the last dominant sample and
  // win_cnt runs from the first accepted pulse of a pattern
  // any rejection, gap overrun or window overrun restarts the pattern
  // from zero; accepting the third pulse raises the internal hit
  // trade-off: the window is checked in every cycle, so a pattern that
  // overruns it by one cycle is lost rather than stretched
  //
  logic [TW-1:0] width_cnt;
  logic [TW-1:0] gap_cnt;
  logic [TW-1:0] win_cnt;
  logic [1:0]    pulse_cnt;
  logic          wake_prev;
  logic          wake_hit;

  function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  wire armed     = sleep_mode && wake_en;
  wire pulse_end = wake_prev && !wake_rx_dominant_i;
  wire width_ok  = (width_cnt > TW'(MIN_CYC))
                && (width_cnt < TW'(MAX_CYC));
  wire too_long  = wake_rx_dominant_i && (width_cnt >= TW'(MAX_CYC));
  wire gap_out   = (pulse_cnt != 2'd0) && !wake_rx_dominant_i
                && (gap_cnt > TW'(GAP_CYC));
  wire win_out   = (pulse_cnt != 2'd0)
                && (win_cnt > TW'(WIN_CYC));
  wire reject    = (pulse_end && !width_ok) || too_long;
  wire accept    = pulse_end && width_ok && !gap_out && !win_out;
  wire third     = accept && (pulse_cnt == 2'(WAKE_PULSES - 1));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      width_cnt <= '0;
      gap_cnt   <= '0;
      win_cnt   <= '0;
      pulse_cnt <= 2'd0;
      wake_prev <= 1'b0;
      wake_hit  <= 1'b0;
    end else if (clk_en_i) begin
      if (!armed || go_wake_sleep) begin
        width_cnt <= '0;
        gap_cnt   <= '0;
        win_cnt   <= '0;
        pulse_cnt <= 2'd0;
        wake_prev <= 1'b0;
        // hit survives only while the interface stays asleep
        wake_hit  <= wake_hit && sleep_mode && !go_active;
      end else begin
        wake_prev <= wake_rx_dominant_i;
        width_cnt <= wake_rx_dominant_i ? sat_inc(width_cnt) : '0;
        gap_cnt   <= wake_rx_dominant_i ? '0 : sat_inc(gap_cnt);
        win_cnt   <= (pulse_cnt == 2'd0 && !accept) ? '0 : sat_inc(win_cnt);
        if (reject || gap_out || win_out || third) begin
          pulse_cnt <= 2'd0;
        end else if (accept) begin
          pulse_cnt <= pulse_cnt + 2'd1;
        end
        if (third) begin
          wake_hit <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wake reporting by chip power state
  //
  // deepest sleep: regulator on, then reset release one edge later, so
  // the host never leaves reset on an unpowered supply
  // stop: one-cycle interrupt pulse plus the sticky flag
  // normal or standby: the sticky flag alone
  // the flag is set in every state so software can always find the
  // cause after it wakes
  //
  wire wake_rise = third && !wake_hit;
  wire in_sleep  = pwr_state_i == CSWD_PWR_SLEEP;
  wire in_stop   = pwr_state_i == CSWD_PWR_STOP;
  // set wins over the read-to-clear
  wire flag_clr  = rd_stat && !sleep_mode;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_wake_flag       <= 1'b0;
      int_pulse_o         <= 1'b0;
      regulator_on_o      <= 1'b0;
      mcu_reset_release_o <= 1'b0;
    end else if (clk_en_i) begin
      int_pulse_o <= wake_rise && in_stop;
      if (wake_rise) begin
        bus_wake_flag <= 1'b1;
      end else if (flag_clr) begin
        bus_wake_flag <= 1'b0;
      end
      // regulator first, reset release on the next edge
      if (wake_rise && in_sleep) begin
        regulator_on_o <= 1'b1;
      end else if (!in_sleep) begin
        regulator_on_o <= 1'b0;
      end
      mcu_reset_release_o <= regulator_on_o && in_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bus short classification
  //
  // the recessive snapshot is taken in active mode whenever the drivers are off with
  // the transmit input high; the dominant half is judged in the last
  // dominant cycle, when the comparators have had the longest to settle
  // a failure seen only in recessive is flagged but stays unidentified,
  // since both lines follow a shorted one while the drivers are off
  // limitation: an idle bus never produces a dominant sample, so the
  // code can only be identified while the host is transmitting
  //
  logic [5:0] rec_snap;
  logic [2:0] same_cnt;
  cswd_fail_e last_code;

  function automatic cswd_fail_e classify(input logic [5:0] r,
                                          input logic [5:0] d);
    // r/d: {lg, hg, lb, hb, l5, h5} in recessive and dominant
    classify = CSWD_FAIL_NONE;
    if (r[5:4] == 2'b00) begin
      classify = (d[5:4] == 2'b01) ? CSWD_FAIL_LO_GND :
                 (d[5:4] == 2'b00) ? CSWD_FAIL_HI_GND :
                 CSWD_FAIL_UNKNOWN;
    end else if (r[3:2] == 2'b11) begin
      classify = (d[3:2] == 2'b11) ? CSWD_FAIL_LO_BATT :
                 (d[3:2] == 2'b01) ? CSWD_FAIL_HI_BATT :
                 CSWD_FAIL_UNKNOWN;
    end else if (r[1:0] == 2'b11) begin
      classify = (d[1:0] == 2'b11) ? CSWD_FAIL_LO_SUPP :
                 (d[1:0] == 2'b01) ? CSWD_FAIL_HI_SUPP :
                 CSWD_FAIL_UNKNOWN;
    end else if (r != 6'h30 || d != 6'h10) begin
      classify = CSWD_FAIL_UNKNOWN;
    end
  endfunction

  wire [5:0] cmp_now   = cmp_i;
  // recessive sample flags a failure early, the line stays unknown
  wire rec_bad = (cmp_now[5:4] != 2'b11) || (cmp_now[3:2] != 2'b00)
              || (cmp_now[1:0] != 2'b00);
  // last dominant cycle: driver on now, transmit input back high
  wire dom_sample = !sleep_mode && txd_i && drive_dominant_o;
  wire rec_sample = !sleep_mode && txd_i && !drive_dominant_o;
  wire cswd_fail_e cyc_code = classify(rec_snap, cmp_now);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rec_snap  <= 6'h30;
      same_cnt  <= 3'h0;
      last_code <= CSWD_FAIL_NONE;
      fail_code <= CSWD_FAIL_NONE;
      fail_flag <= 1'b0;
      failure_unidentified_flag <= 1'b0;
    end else if (clk_en_i) begin
      if (rec_sample) begin
        rec_snap <= cmp_now;
        if (rec_bad) begin
          fail_flag <= 1'b1;
          if (fail_code == CSWD_FAIL_NONE)
            failure_unidentified_flag <= 1'b1;
        end
      end
      if (dom_sample && !next_drive) begin
        last_code <= cyc_code;
        same_cnt  <= (cyc_code == last_code && same_cnt != 3'h7)
                   ? same_cnt + 3'h1 : 3'h1;
        if (cyc_code != CSWD_FAIL_NONE) begin
          fail_flag <= 1'b1;
        end
        if (cyc_code == last_code && cyc_code != CSWD_FAIL_NONE
            && same_cnt >= 3'(DIAG_CONFIRM_CYCLES - 1)) begin
          fail_code <= cyc_code;
          failure_unidentified_flag <= 1'b0;
        end else if (cyc_code != CSWD_FAIL_NONE) begin
          failure_unidentified_flag <= 1'b1;
        end
      end
    end
  end

endmodule // cswd_ctrl

// [cswd_ctrl_properties.sv]
// cswd_ctrl_properties: port assertions for cswd_ctrl.
// assumes clk_en_i is held high by the bench.
`timescale 1ns/1ps
module cswd_ctrl_properties
  import cswd_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  // register port
  input wire cswd_req_s  req_i,
  input wire logic [7:0] rdata_o,
  // host and bus side
  input wire cswd_pwr_e  pwr_state_i,
  input wire logic       txd_i,
  input wire logic       rxd_o,
  input wire logic       bus_diff_dominant_i,
  input wire logic       drive_dominant_o,
  input wire logic       bias_recessive_o,
  input wire logic       rx_enable_o,
  // wake reporting
  input wire logic       regulator_on_o,
  input wire logic       mcu_reset_release_o,
  input wire logic       int_pulse_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////
  // mirror of the mode bits; age settles after mode changes
  logic [1:0] ctl;
  logic [1:0] age;
  wire        ctl_wr = req_i.wr && req_i.addr == REG_CTRL;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl <= 2'h0;
      age <= 2'h0;
    end else begin
      if (ctl_wr) ctl <= req_i.wdata[1:0];
      if (ctl_wr || ctl[0]) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
    end
  end
  sequence s_slp; ctl_wr && req_i.wdata[0]; endsequence
  sequence s_off;
    !bias_recessive_o && !rx_enable_o && !drive_dominant_o;
  endsequence
  ////////////////////////////////////////////////////////////
  AST_SLEEP_OFF: assert property (s_slp |-> ##2 s_off)
    else $error("line drive or receiver left on in sleep");
  AST_BACK_RECESSIVE: assert property (ctl_wr && !req_i.wdata[0]
    |-> ##2 bias_recessive_o && rx_enable_o)
    else $error("lines not recessive after leaving sleep");
  AST_TX_DRIVE: assert property (age == 2'h3
    |-> drive_dominant_o == !$past(txd_i))
    else $error("driver does not follow transmit input");
  AST_RX_REPORT: assert property (age == 2'h3
    |-> rxd_o == !$past(bus_diff_dominant_i))
    else $error("receive output does not follow bus");
  AST_INT_STOP: assert property (int_pulse_o
    |-> $past(pwr_state_i) == CSWD_PWR_STOP ##1 !int_pulse_o)
    else $error("interrupt pulse outside stop or too long");
  AST_REG_ORDER: assert property ($rose(regulator_on_o)
    |-> pwr_state_i == CSWD_PWR_SLEEP && !mcu_reset_release_o
    ##1 mcu_reset_release_o)
    else $error("regulator and reset release out of order");
  AST_RDATA_IDLE: assert property (!$past(req_i.rd)
    |-> rdata_o == 8'h00)
    else $error("read data outside read answer cycle");
  AST_NO_WAKE_DIS: assert property (ctl == 2'h1 && $past(ctl) == 2'h1
    |-> !int_pulse_o && !$rose(regulator_on_o))
    else $error("wake reported with wake disabled");
endmodule // cswd_ctrl_properties

// [cswd_bus_model.sv]
// cswd_bus_model: bus lines, wake receiver and comparators.
// assumes the bench picks the injected short through fault_i.
`timescale 1ns/1ps
module cswd_bus_model
  import cswd_pkg::*;
(
  // clock and device drive
  input  wire logic       clk_i,
  input  wire logic       drive_i,
  input  wire cswd_fail_e fault_i,
  // line levels seen by the device
  output logic            diff_o,
  output logic            wake_o,
  output cswd_cmp_s       cmp_o
);
  logic [1:0] g;
  logic [1:0] b;
  logic [1:0] s;
  initial wake_o = 1'b0;
  // no other node talks: bus is dominant only when driven
  assign diff_o = drive_i;
  assign cmp_o  = cswd_cmp_s'({g, b, s});
  always_comb begin
    g = {!drive_i, 1'b1};
    b = 2'h0;
    s = 2'h0;
    case (fault_i)
      CSWD_FAIL_LO_GND:  g = {1'b0, drive_i};
      CSWD_FAIL_HI_GND:  g = 2'h0;
      CSWD_FAIL_LO_BATT: b = 2'h3;
      CSWD_FAIL_HI_BATT: b = {!drive_i, 1'b1};
      CSWD_FAIL_LO_SUPP: s = 2'h3;
      CSWD_FAIL_HI_SUPP: s = {!drive_i, 1'b1};
      default: ;
    endcase
  end
  // one dominant pulse of w cycles, then gap recessive cycles
  task automatic pulse(input int w, input int gap);
    @(posedge clk_i);
    wake_o <= 1'b1;
    repeat (w) @(posedge clk_i);
    wake_o <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask
endmodule // cswd_bus_model

// [tb.sv]
// tb: self-checking bench for cswd_ctrl with short wake timers.
// assumes cswd_bus_model stands in for the bus and wake receiver.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
  import cswd_pkg::*;
  logic       clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  cswd_req_s  req = '0;
  cswd_pwr_e  pwr = CSWD_PWR_NORMAL;
  cswd_fail_e flt = CSWD_FAIL_NONE;
  logic       txd = 1'b1;
  logic [7:0] rdata;
  logic [7:0] rd_v;
  logic       rxd, drv, bias, rxen, reg_on, rel, intp, diff, wake;
  cswd_cmp_s  cmp;
  int         n_errors = 0;
  int         check_count = 0;
  int         n_int = 0;
  cswd_pwr_e  ps[4] = '{CSWD_PWR_NORMAL, CSWD_PWR_STANDBY,
                        CSWD_PWR_STOP, CSWD_PWR_SLEEP};
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (intp === 1'b1) n_int++;
  cswd_ctrl #(.MIN_CYC(4), .MAX_CYC(40), .GAP_CYC(40), .WIN_CYC(80)) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .req_i(req),
    .rdata_o(rdata), .pwr_state_i(pwr), .txd_i(txd), .rxd_o(rxd),
    .bus_diff_dominant_i(diff), .wake_rx_dominant_i(wake), .cmp_i(cmp),
    .drive_dominant_o(drv), .bias_recessive_o(bias), .rx_enable_o(rxen),
    .regulator_on_o(reg_on), .mcu_reset_release_o(rel),
    .int_pulse_o(intp));
  cswd_bus_model u_bus (.clk_i(clk_i), .drive_i(drv), .fault_i(flt),
    .diff_o(diff), .wake_o(wake), .cmp_o(cmp));
  ////////////////////////////////////////////////////////////
  task automatic rst();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    req <= '0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    req <= '0;
    #1 rd_v = rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      txd <= 1'b0;
      repeat (4) @(posedge clk_i);
      txd <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task automatic t_regs();
    settle(1);
    `CHK("bias", 1'b1, bias)
    wr(REG_CTRL, 8'h02);
    rd(REG_CTRL);
    `CHK("ctrl", 8'h02, rd_v)
    wr(REG_STATUS, 8'hFF);
    rd(REG_STATUS);
    `CHK("status", 8'h00, rd_v)
    rd(4'hF);
    `CHK("unmapped", 8'h00, rd_v)
    wr(REG_CTRL, 8'h00);
  endtask
  task automatic t_active_comm_mode();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      txd <= i[0];
      settle(2);
      `CHK("drive", !i[0], drv)
      `CHK("rxd", i[0], rxd)
    end
  endtask
  task automatic t_sleep();
    wr(REG_CTRL, 8'h01);
    @(posedge clk_i);
    txd <= 1'b0;
    repeat (3) u_bus.pulse(10, 10);
    settle(2);
    `CHK("off", 3'h0, {drv, bias, rxen})
    rd(REG_STATUS);
    `CHK("ignored", 8'h08, rd_v)
    @(posedge clk_i);
    txd <= 1'b1;
    wr(REG_CTRL, 8'h00);
    settle(2);
    `CHK("recessive", 3'h3, {drv, bias, rxen})
  endtask
  task automatic t_wake(input cswd_pwr_e p);
    rst();
    pwr <= p;
    n_int = 0;
    wr(REG_CTRL, 8'h03);
    repeat (3) u_bus.pulse(10, 10);
    settle(3);
    `CHK("int", p == CSWD_PWR_STOP, n_int == 1)
    `CHK("regul", p == CSWD_PWR_SLEEP, reg_on & rel)
    wr(REG_CTRL, 8'h00);
    rd(REG_STATUS);
    `CHK("flag", 1'b1, rd_v[ST_WAKE_BIT])
    rd(REG_STATUS);
    `CHK("cleared", 1'b0, rd_v[ST_WAKE_BIT])
  endtask
  task automatic t_bad(input int w, input int g);
    wr(REG_CTRL, 8'h03);
    u_bus.pulse(10, g);
    u_bus.pulse(w, g);
    u_bus.pulse(10, g);
    rd(REG_STATUS);
    `CHK("no wake", 1'b0, rd_v[ST_WAKE_BIT])
    wr(REG_CTRL, 8'h00);
  endtask
  task automatic t_diag(input cswd_fail_e f);
    rst();
    flt <= f;
    toggle(1);
    rd(REG_STATUS);
    `CHK("unid", f != 0, rd_v[ST_UNID_BIT])
    toggle(6);
    rd(REG_DIAG);
    `CHK("code", f, rd_v[2:0])
    rd(REG_STATUS);
    `CHK("fail", {1'b0, f != 0}, rd_v[2:1])
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    rst();
    t_regs();
    t_active_comm_mode();
    t_sleep();
    foreach (ps[i]) t_wake(ps[i]);
    t_bad(4, 10);
    t_bad(40, 10);
    t_bad(10, 45);
    t_bad(35, 20);
    for (int f = 0; f < 7; f++) t_diag(cswd_fail_e'(f));
    complete_run();
  end
endmodule // tb
bind cswd_ctrl cswd_ctrl_properties u_props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .rdata_o(rdata_o),
  .pwr_state_i(pwr_state_i), .txd_i(txd_i), .rxd_o(rxd_o),
  .bus_diff_dominant_i(bus_diff_dominant_i),
  .drive_dominant_o(drive_dominant_o), .bias_recessive_o(bias_recessive_o),
  .rx_enable_o(rx_enable_o), .regulator_on_o(regulator_on_o),
  .mcu_reset_release_o(mcu_reset_release_o), .int_pulse_o(int_pulse_o));
